// file: design/rss_ramp_seq.v
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "rss_consts.vh"

// What this block does
// - Eight segments, each with a signed 30-bit increment added per tick.
// - Segment fastlock bit drives the fastlock enable while it runs.
// - Half-rate bit makes each tick take two phase-detector clocks.
// - Segment lasts its length field in ticks, capped at 55536.
// - Two-bit flag field drives the two marker outputs while running.
// - Accumulator-clear bit zeroes the accumulator on segment entry.
// - Advance condition: length expiry, or trigger A, B or C.
// - On leaving, jump to the segment in the successor field.
module rss_ramp_seq #(
	parameter NSEG = `RSS_NUM_SEG,
	parameter IDXW = `RSS_IDX_W,
	parameter INCW = `RSS_INC_W,
	parameter LENW = `RSS_LEN_W,
	parameter ACCW = `RSS_ACC_W,
	parameter CTLW = `RSS_CTL_W
) (
	// Clock and reset (phase-detector clock)
	input  wire            clk_sys,
	input  wire            rst_n,
	// Register port
	input  wire [4:0]      regAddr,
	input  wire [31:0]     regWrData,
	input  wire            regWr,
	input  wire            regRd,
	output reg  [31:0]     regRdData,
	// Run control and trigger pins
	input  wire            rampRun,
	input  wire            eventSourceA,
	input  wire            eventSourceB,
	input  wire            eventSourceC,
	// Outputs toward modulator and pins
	output reg  [ACCW-1:0] rampAcc,
	output reg  [IDXW-1:0] segIndex,
	output reg             fastlockEn,
	output reg             markerOutputLo,
	output reg             markerOutputHi,
	output reg             segmentEnter
);
	// Sequencer states
	localparam ST_IDLE = 2'h0;
	localparam ST_RUN  = 2'h1;
	localparam ST_HOLD = 2'h2;

	reg  [1:0]      state_ff;
	reg  [1:0]      nxt_state;
	reg  [LENW-1:0] lenCnt_ff;
	reg  [LENW-1:0] nxt_lenCnt;
	reg             halfPh_ff;
	reg             nxt_halfPh;
	reg  [ACCW-1:0] nxt_acc;
	reg  [IDXW-1:0] nxt_seg;
	reg             nxt_enter;
	reg  [31:0]     nxt_rd;
	reg             runPrev_ff;
	reg  [CTLW-1:0] curCtl_ff;
	reg  [INCW-1:0] curInc_ff;

	wire [2:0]      trigSync;
	wire [INCW-1:0] swInc;
	wire [LENW-1:0] swLen;
	wire [CTLW-1:0] swCtl;
	wire [INCW-1:0] seqInc;
	wire [LENW-1:0] seqLen;
	wire [CTLW-1:0] seqCtl;
	wire [IDXW-1:0] swIdx;
	wire [1:0]      swWord;
	wire            isSegAddr;
	wire            wrInc;
	wire            wrLen;
	wire            wrCtl;

	// Sign-extend the 30-bit increment to accumulator width
	function [ACCW-1:0] sext;
		input [INCW-1:0] v;
		begin
			sext = {{(ACCW-INCW){v[INCW-1]}}, v};
		end
	endfunction

	// Saturate the programmed length to the documented maximum
	function [LENW-1:0] capLen;
		input [LENW-1:0] v;
		begin
			capLen = (v > `RSS_LEN_MAX) ? `RSS_LEN_MAX : v;
		end
	endfunction

	// Successor index held in a control word
	function [IDXW-1:0] succOf;
		input [CTLW-1:0] c;
		begin
			succOf = c[`RSS_CTL_NXT_HI:`RSS_CTL_NXT_LO];
		end
	endfunction

	// Trigger events arrive from pins: synchronise first
	rss_sync2 #(
		.WIDTH (3)
	) uTrigSync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.dIn     ({eventSourceC, eventSourceB, eventSourceA}),
		.dOut    (trigSync)
	);

	// Address decode: index bits select segment, low bits the word
	assign swIdx     = regAddr[4:2];
	assign swWord    = regAddr[1:0];
	assign isSegAddr = (regAddr != `RSS_ADDR_RUN);
	assign wrInc = regWr && isSegAddr && (swWord == `RSS_WORD_INC);
	assign wrLen = regWr && isSegAddr && (swWord == `RSS_WORD_LEN);
	assign wrCtl = regWr && isSegAddr && (swWord == `RSS_WORD_CTL);

	rss_seg_table #(
		.NSEG (NSEG),
		.IDXW (IDXW),
		.INCW (INCW),
		.LENW (LENW),
		.CTLW (CTLW)
	) uTable (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.wrInc   (wrInc),
		.wrLen   (wrLen),
		.wrCtl   (wrCtl),
		.wrIdx   (swIdx),
		.wrData  (regWrData),
		.swIdx   (swIdx),
		.seqIdx  (nxt_seg),
		.swInc   (swInc),
		.swLen   (swLen),
		.swCtl   (swCtl),
		.seqInc  (seqInc),
		.seqLen  (seqLen),
		.seqCtl  (seqCtl)
	);

	// Current segment's fields come from the entry latch
	wire [CTLW-1:0] curCtl;
	wire [INCW-1:0] curInc;
	wire [1:0]      curAdv;
	wire            trigHit;
	wire            tick;
	assign curCtl = curCtl_ff;
	assign curInc = curInc_ff;
	assign curAdv = curCtl[`RSS_CTL_ADV_HI:`RSS_CTL_ADV_LO];
	// Trigger is a level sampled each clock once synchronised
	assign trigHit = (curAdv == `RSS_ADV_EVENT_SOURCE_A) ? trigSync[0] :
	                 (curAdv == `RSS_ADV_EVENT_SOURCE_B) ? trigSync[1] :
	                 (curAdv == `RSS_ADV_EVENT_SOURCE_C) ? trigSync[2] :
	                 1'b0;
	// A tick is every clock, or every second one at half rate
	assign tick = !curCtl[`RSS_CTL_HALF] || halfPh_ff;

	// Sequencer: run, hold for trigger, and segment switching
	always @* begin
		nxt_state  = state_ff;
		nxt_lenCnt = lenCnt_ff;
		nxt_halfPh = halfPh_ff;
		nxt_acc    = rampAcc;
		nxt_seg    = segIndex;
		nxt_enter  = 1'b0;
		case (state_ff)
		ST_IDLE: begin
			// Rising run enters segment zero
			if (rampRun && !runPrev_ff) begin
				nxt_seg   = {IDXW{1'b0}};
				nxt_enter = 1'b1;
			end
		end
		ST_RUN: begin
			if (curCtl[`RSS_CTL_HALF])
				nxt_halfPh = !halfPh_ff;
			else
				nxt_halfPh = 1'b0;
			if (curAdv != `RSS_ADV_LEN && trigHit) begin
				nxt_seg   = succOf(curCtl);
				nxt_enter = 1'b1;
			end else if (tick && lenCnt_ff != {LENW{1'b0}}) begin
				nxt_acc    = rampAcc + sext(curInc);
				nxt_lenCnt = lenCnt_ff - {{(LENW-1){1'b0}}, 1'b1};
			end else if (lenCnt_ff == {LENW{1'b0}}) begin
				if (curAdv == `RSS_ADV_LEN) begin
					nxt_seg   = succOf(curCtl);
					nxt_enter = 1'b1;
				end else begin
					nxt_state = ST_HOLD;
				end
			end
		end
		ST_HOLD: begin
			// Accumulator frozen until the chosen trigger
			if (trigHit) begin
				nxt_seg   = succOf(curCtl);
				nxt_enter = 1'b1;
			end
		end
		default: begin
			nxt_state = ST_IDLE;
		end
		endcase
		// Entry: reload length, optional clear, restart tick phase
		if (nxt_enter) begin
			nxt_state  = ST_RUN;
			nxt_lenCnt = capLen(seqLen);
			nxt_halfPh = 1'b0;
			if (seqCtl[`RSS_CTL_CLR])
				nxt_acc = {ACCW{1'b0}};
		end
		// Dropping run stops the sequencer where it stands
		if (!rampRun) begin
			nxt_state = ST_IDLE;
			nxt_enter = 1'b0;
			nxt_seg   = segIndex;
		end
	end

	// Sequencer registers and segment-driven outputs
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_ff       <= ST_IDLE;
			lenCnt_ff      <= {LENW{1'b0}};
			halfPh_ff      <= 1'b0;
			rampAcc        <= {ACCW{1'b0}};
			segIndex       <= {IDXW{1'b0}};
			segmentEnter   <= 1'b0;
			runPrev_ff     <= 1'b0;
			fastlockEn     <= 1'b0;
			markerOutputLo <= 1'b0;
			markerOutputHi <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			lenCnt_ff    <= nxt_lenCnt;
			halfPh_ff    <= nxt_halfPh;
			rampAcc      <= nxt_acc;
			segIndex     <= nxt_seg;
			segmentEnter <= nxt_enter;
			runPrev_ff   <= rampRun;
			// Registered from next state so outputs align with segment
			if (nxt_state == ST_IDLE) begin
				fastlockEn     <= 1'b0;
				markerOutputLo <= 1'b0;
				markerOutputHi <= 1'b0;
			end else begin
				fastlockEn     <= seqCtl[`RSS_CTL_FL];
				markerOutputLo <= seqCtl[`RSS_CTL_FLAG_LO];
				markerOutputHi <= seqCtl[`RSS_CTL_FLAG_HI];
			end
		end
	end

	// Segment fields latched on entry; a rewrite of the running segment reaches the ticks
	// only at its next entry, though fastlock and markers follow the new control word at once
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			curCtl_ff <= {CTLW{1'b0}};
			curInc_ff <= {INCW{1'b0}};
		end else if (nxt_enter) begin
			curCtl_ff <= seqCtl;
			curInc_ff <= seqInc;
		end
	end

	// Status word: count in the low half, index and state above it
	wire [31:0] statWord;
	assign statWord = {{(32-LENW-IDXW-3){1'b0}}, state_ff, 1'b0,
	                   segIndex, lenCnt_ff};

	// Read mux; status word reports live sequencer state
	always @* begin
		nxt_rd = 32'h00000000;
		if (!isSegAddr)
			nxt_rd = {31'h00000000, rampRun};
		else
			case (swWord)
			`RSS_WORD_INC:
				nxt_rd = {{(32-INCW){1'b0}}, swInc};
			`RSS_WORD_LEN:
				nxt_rd = {{(32-LENW){1'b0}}, swLen};
			`RSS_WORD_CTL:
				nxt_rd = {{(32-CTLW){1'b0}}, swCtl};
			default:
				nxt_rd = statWord;
			endcase
	end

	// Read data stands one cycle after the read strobe
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			regRdData <= 32'h00000000;
		end else if (regRd) begin
			regRdData <= nxt_rd;
		end else begin
			regRdData <= 32'h00000000;
		end
	end
endmodule

// file: design/rss_consts.vh
`ifndef RSS_CONSTS_VH
`define RSS_CONSTS_VH

// Segment table geometry
`define RSS_NUM_SEG      8
`define RSS_IDX_W        3
`define RSS_INC_W        30
`define RSS_LEN_W        16
`define RSS_LEN_MAX      16'hD8F0
`define RSS_ACC_W        32

// Register index map: segment s word w at (s << 2) | w
`define RSS_WORD_INC     2'h0
`define RSS_WORD_LEN     2'h1
`define RSS_WORD_CTL     2'h2
`define RSS_WORD_STAT    2'h3
`define RSS_ADDR_W       5
`define RSS_ADDR_RUN     5'h1F

// Control word field positions
`define RSS_CTL_FL       0
`define RSS_CTL_HALF     1
`define RSS_CTL_CLR      2
`define RSS_CTL_FLAG_LO  3
`define RSS_CTL_FLAG_HI  4
`define RSS_CTL_ADV_LO   5
`define RSS_CTL_ADV_HI   6
`define RSS_CTL_NXT_LO   7
`define RSS_CTL_NXT_HI   9
`define RSS_CTL_W        10

// Advance condition codes
`define RSS_ADV_LEN      2'h0
`define RSS_ADV_EVENT_SOURCE_A   2'h1
`define RSS_ADV_EVENT_SOURCE_B   2'h2
`define RSS_ADV_EVENT_SOURCE_C   2'h3

`endif

// file: design/rss_sync2.v
`timescale 1ns/10ps
`include "rss_consts.vh"

// Two-stage synchroniser for pin-level trigger events
module rss_sync2 #(
	parameter WIDTH = 3
) (
	// Clock and reset
	input  wire             clk_sys,
	input  wire             rst_n,
	// Data
	input  wire [WIDTH-1:0] dIn,
	output wire [WIDTH-1:0] dOut
);
	reg [WIDTH-1:0] stage1_ff;
	reg [WIDTH-1:0] stage2_ff;

	// First stage feeds only the second
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stage1_ff <= {WIDTH{1'b0}};
			stage2_ff <= {WIDTH{1'b0}};
		end else begin
			stage1_ff <= dIn;
			stage2_ff <= stage1_ff;
		end
	end

	assign dOut = stage2_ff;
endmodule

// file: design/rss_seg_table.v
`timescale 1ns/10ps
`include "rss_consts.vh"

// Per-segment parameter storage, written by software, read by index
module rss_seg_table #(
	parameter NSEG  = `RSS_NUM_SEG,
	parameter IDXW  = `RSS_IDX_W,
	parameter INCW  = `RSS_INC_W,
	parameter LENW  = `RSS_LEN_W,
	parameter CTLW  = `RSS_CTL_W
) (
	// Clock and reset
	input  wire            clk_sys,
	input  wire            rst_n,
	// Write port
	input  wire            wrInc,
	input  wire            wrLen,
	input  wire            wrCtl,
	input  wire [IDXW-1:0] wrIdx,
	input  wire [31:0]     wrData,
	// Read ports, software and sequencer
	input  wire [IDXW-1:0] swIdx,
	input  wire [IDXW-1:0] seqIdx,
	output wire [INCW-1:0] swInc,
	output wire [LENW-1:0] swLen,
	output wire [CTLW-1:0] swCtl,
	output wire [INCW-1:0] seqInc,
	output wire [LENW-1:0] seqLen,
	output wire [CTLW-1:0] seqCtl
);
	reg [INCW-1:0] incMem_ff [0:NSEG-1];
	reg [LENW-1:0] lenMem_ff [0:NSEG-1];
	reg [CTLW-1:0] ctlMem_ff [0:NSEG-1];
	integer i;

	// All fields clear at power-on
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (i = 0; i < NSEG; i = i + 1) begin
				incMem_ff[i] <= {INCW{1'b0}};
				lenMem_ff[i] <= {LENW{1'b0}};
				ctlMem_ff[i] <= {CTLW{1'b0}};
			end
		end else begin
			if (wrInc)
				incMem_ff[wrIdx] <= wrData[INCW-1:0];
			if (wrLen)
				lenMem_ff[wrIdx] <= wrData[LENW-1:0];
			if (wrCtl)
				ctlMem_ff[wrIdx] <= wrData[CTLW-1:0];
		end
	end

	assign swInc  = incMem_ff[swIdx];
	assign swLen  = lenMem_ff[swIdx];
	assign swCtl  = ctlMem_ff[swIdx];
	assign seqInc = incMem_ff[seqIdx];
	assign seqLen = lenMem_ff[seqIdx];
	assign seqCtl = ctlMem_ff[seqIdx];
endmodule

// file: bench/rss_ramp_seq_props.sv
`timescale 1ns/10ps

// Pin checks against a shadow of the segment control words
module rss_ramp_seq_props (
	// Clock and reset
	input logic        clk_sys,
	input logic        rst_n,
	// Register writes
	input logic [4:0]  regAddr,
	input logic [31:0] regWrData,
	input logic        regWr,
	// Run and trigger pins
	input logic        rampRun,
	input logic        eventSourceA,
	input logic        eventSourceB,
	input logic        eventSourceC,
	// Sequencer outputs
	input logic [2:0]  segIndex,
	input logic [31:0] rampAcc,
	input logic        fastlockEn,
	input logic        markerOutputLo,
	input logic        markerOutputHi,
	input logic        segmentEnter
);
	logic [9:0] ctl_ff [8];
	wire  [9:0] curCtl = ctl_ff[segIndex];
	wire  [2:0] nxtSeg = curCtl[9:7];
	wire        tMode  = curCtl[6:5] != 2'h0;
	wire        tSel   = curCtl[6] ? (curCtl[5] ? eventSourceC : eventSourceB)
	                               : eventSourceA;

	// Shadow only; rewriting control words mid-run would blur the checks
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 8; i++)
				ctl_ff[i] <= 10'h000;
		end else if (regWr && regAddr[1:0] == 2'h2) begin
			ctl_ff[regAddr[4:2]] <= regWrData[9:0];
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_idle_outs_low: assert property (
		!rampRun |=> !fastlockEn && !markerOutputLo && !markerOutputHi)
		else $error("outputs active while idle");
	a_fastlock_follow: assert property (
		rampRun |=> fastlockEn == curCtl[0])
		else $error("fastlock differs from segment");
	a_marker_follow: assert property (
		rampRun |=> {markerOutputHi, markerOutputLo} == curCtl[4:3])
		else $error("markers differ from segment");
	a_start_seg_zero: assert property (
		$rose(rampRun) |=> segmentEnter && segIndex == 3'h0)
		else $error("run start missed segment zero");
	a_next_segment: assert property (
		segmentEnter && $past(rampRun) && $past(rampRun, 2)
		|-> segIndex == $past(nxtSeg))
		else $error("wrong successor");
	a_clear_entry: assert property (
		segmentEnter && curCtl[2] |-> rampAcc == 32'h0)
		else $error("accumulator not cleared");
	a_trig_wait: assert property (
		(rampRun && tMode && !tSel && !segmentEnter) [*3] |=> !segmentEnter)
		else $error("left without trigger");
	a_trig_leave: assert property (
		rampRun && tMode && tSel ##1 (rampRun && !segmentEnter) [*2]
		|=> segmentEnter)
		else $error("trigger ignored");
endmodule

bind rss_ramp_seq rss_ramp_seq_props u_props (.*);

// file: bench/rss_trig_model.sv
`timescale 1ns/10ps

// Trigger sources: one clean pulse a fixed time after each request
module rss_trig_model #(
	parameter DLY = 32
) (
	// Clock and reset
	input  wire       clk_sys,
	input  wire       rst_n,
	// Request from bench
	input  wire       fireReq,
	input  wire [1:0] fireSel,
	// Pins A, B, C
	output wire [2:0] pulse
);
	reg [7:0] cnt_ff;
	reg [1:0] sel_ff;
	reg [2:0] pulse_ff;

	assign pulse = pulse_ff;

	// Pins rest low between events; a new request overrides an old one
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff   <= 8'h00;
			sel_ff   <= 2'h0;
			pulse_ff <= 3'h0;
		end else begin
			pulse_ff <= 3'h0;
			if (fireReq) begin
				cnt_ff <= 8'(DLY);
				sel_ff <= fireSel;
			end else if (cnt_ff != 8'h00) begin
				cnt_ff <= cnt_ff - 8'h01;
				if (cnt_ff == 8'h01)
					pulse_ff <= 3'h1 << (sel_ff - 2'h1);
			end
		end
	end
endmodule

// file: bench/tb_top.sv
`timescale 1ns/10ps
`include "rss_consts.vh"

module tb_top;
	logic        clk_sys = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
	logic        rampRun = 1'b0, fireReq = 1'b0;
	logic [1:0]  fireSel = 2'h0;
	logic [4:0]  regAddr = 5'h00;
	logic [31:0] regWrData = 32'h0, rng = 32'h000169C0;
	wire  [31:0] regRdData, rampAcc;
	wire  [2:0]  segIndex, pulse;
	wire         fastlockEn, markerOutputLo, markerOutputHi, segmentEnter;
	int          fails = 0, cmp_count = 0;
	logic [29:0] incT [8];
	logic [15:0] lenT [8];
	logic [9:0]  ctlT [8];

	// 250 MHz system clock
	always #2 clk_sys = ~clk_sys;

	// Design and trigger sources
	rss_ramp_seq dut (.*, .eventSourceA(pulse[0]), .eventSourceB(pulse[1]),
		.eventSourceC(pulse[2]));
	rss_trig_model prt (.*);

	function automatic logic [31:0] nxtRng(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Length is capped, so long fields count only up to the maximum
	function automatic int segLen(input int s);
		return lenT[s] > `RSS_LEN_MAX ? `RSS_LEN_MAX : lenT[s];
	endfunction
	function automatic logic [31:0] endAcc(input logic [31:0] b, input int s);
		return b + 32'(segLen(s)) * {{2{incT[s][29]}}, incT[s]};
	endfunction
	function automatic logic [31:0] wordOf(input int a);
		case (a % 4)
			0: return {2'h0, incT[a / 4]};
			1: return {16'h0, lenT[a / 4]};
			default: return {22'h0, ctlT[a / 4]};
		endcase
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		if (fails == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wr(input int a, input logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= 5'(a);
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask
	task automatic rd(input int a, output logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= 5'(a);
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 d = regRdData;
	endtask

	// Follows n segment entries; trigger segments get a late pulse
	task automatic runSegs(input int n);
		int s, k, dur, lim, lo, hi;
		logic f;
		logic [31:0] acc, prev;
		s = 0;
		k = 0;
		dur = 0;
		lim = 0;
		lo = 0;
		hi = 0;
		acc = 32'h0;
		@(posedge clk_sys);
		rampRun <= 1'b1;
		while (k < n) begin
			prev = rampAcc;
			@(posedge clk_sys);
			#1 f = 1'b0;
			dur++;
			if (++lim > 60000) begin
				fails++;
				stop_test();
			end
			if (segmentEnter === 1'b1) begin
				if (k > 0) begin
					chk(prev, endAcc(acc, s));
					chk(32'(dur >= lo && dur <= hi), 32'h1);
					acc = endAcc(acc, s);
					s = ctlT[s][9:7];
				end
				chk({29'h0, segIndex}, 32'(s));
				chk({29'h0, markerOutputHi, markerOutputLo, fastlockEn},
					{29'h0, ctlT[s][4:3], ctlT[s][0]});
				if (ctlT[s][2])
					acc = 32'h0;
				lo = ctlT[s][1] ? 2 * segLen(s) : segLen(s) + 1;
				hi = ctlT[s][1] ? lo + 1 : lo;
				f = ctlT[s][6:5] != 2'h0;
				if (f)
					hi = 99999;
				dur = 0;
				k++;
			end
			fireReq <= f;
			fireSel <= ctlT[s][6:5];
		end
		@(posedge clk_sys);
		rampRun <= 1'b0;
		fireReq <= 1'b0;
	endtask

	// Reset values, ignored run-status write, random table, capped length
	initial begin
		logic [31:0] d;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		for (int a = 0; a < 32; a++) begin
			rd(a, d);
			chk(d, 32'h0);
		end
		wr(31, 32'hFFFFFFFF);
		rd(31, d);
		chk(d, 32'h0);
		// Segment zero always clears so repeats start clean
		for (int s = 0; s < 8; s++) begin
			rng = nxtRng(rng);
			incT[s] = rng[31:2];
			lenT[s] = s == 5 ? 16'h0 : 16'(rng[2:0]) + 16'h2;
			ctlT[s] = {3'(s + 1), s < 4 ? 2'(s) : 2'h0, 2'(s / 2),
				s == 0 || rng[6], rng[5] && s != 5, s[0]};
		end
		for (int a = 0; a < 32; a++)
			if (a % 4 != 3)
				wr(a, wordOf(a));
		for (int a = 0; a < 32; a++)
			if (a % 4 != 3) begin
				rd(a, d);
				chk(a % 4 == 0 ? d & 32'h3FFFFFFF : d, wordOf(a));
			end
		runSegs(9);
		lenT[0] = 16'hFFFF;
		ctlT[0] = 10'h004;
		wr(1, 32'h0000FFFF);
		wr(2, 32'h00000004);
		runSegs(2);
		stop_test();
	end
endmodule
